// ==== hdl/lpc_pkg.sv ====
/*
 * Shared constants and carrier types of the low-power counter with its
 * periodic interval timer. Assumes a single 100 MHz system clock domain.
 */
package lpc_pkg;
   localparam int CNT_W        = 16;              // Counter width
   localparam int PRESC_W      = 15;              // Prescaler width
   localparam int ULP_DIV_W    = 5;               // Divide-by-32 stage width
   localparam int PIT_EV_N     = 8;               // Number of interval event lines
   localparam int PIT_EV_TOP   = 13;              // Log2 of slowest event interval
   localparam logic [3:0] PIT_PER_MAX = 4'hE;     // Largest valid interrupt period code
   // Reference clock source codes
   localparam logic [1:0] SRC_XTAL  = 2'h0;       // Crystal oscillator
   localparam logic [1:0] SRC_EXT   = 2'h1;       // External clock input
   localparam logic [1:0] SRC_ULP   = 2'h2;       // Ultra-low-power oscillator
   localparam logic [1:0] SRC_ULP32 = 2'h3;       // Same oscillator divided by 32
   // Reset values
   localparam logic [15:0] CNT_RST = 16'h0000;    // Counter
   localparam logic [15:0] CMP_RST = 16'h0000;    // Compare value
   localparam logic [15:0] PER_RST = 16'hFFFF;    // Period value

   // Counter control word
   typedef struct packed {
      logic       runStdby;                       // Keep counting in standby
      logic [3:0] presc;                          // Divide by 2^presc
      logic       enable;                         // Counter enable
   } lpc_ctrl_t;

   // Periodic timer control word
   typedef struct packed {
      logic [3:0] period;                         // Interrupt every 2^(period+1)
      logic       enable;                         // Timer enable
   } lpc_pit_ctrl_t;

   // Interrupt flags, also used for enables and clear masks
   typedef struct packed {
      logic periodic_interval_timer;                                  // Periodic interval
      logic cmp;                                  // Compare match
      logic ovf;                                  // Overflow
   } lpc_flags_t;
endpackage

// ==== hdl/lpc_counter.sv ====
/*
 * Low-power counter with periodic interval timer: clock source select,
 * prescaler, 16-bit counter with compare and period, interval timer,
 * interrupt flags, events and wake-up request.
 * Assumes slow reference clocks arrive as plain inputs synchronous to mclk
 * and that mclk is much faster than any of them.
 */
// Notes on behaviour
// - 16-bit counter advances once per prescaled tick
// - Reference picked from crystal, external, ULP, ULP/32
// - 15-bit prescaler divides reference before counter
// - Counter compared to compare and period continuously
// - Compare match signalled on count after equality
// - Overflow on count after period, counter wraps zero
// - Compare and overflow each independently interrupt/event
// - Counter runs in idle, in standby only with runStdby; timer runs in both; wake request raised from sleep
// - Periodic timer enabled independently of counter
// - Timer interrupt every 2^k periods, 4..32768
// - Timer events at 64..8192 periods, one line each
// - Timer uses same selected reference clock
// - Request asserted while flag and enable set
// - Counter enable bit starts and stops counting
// - Busy flags while writes cross to slow domain
// - Debug halt stops both unless debug-run set
`timescale 1ns/1ns
module lpc_counter (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  refXtal,
   input  wire logic                  refExt,
   input  wire logic                  refUlp,
   input  wire logic [1:0]            clkSel,
   input  wire logic                  ctrlWr,
   input  wire lpc_pkg::lpc_ctrl_t    ctrlData,
   input  wire logic                  cmpWr,
   input  wire logic [15:0]           cmpData,
   input  wire logic                  perWr,
   input  wire logic [15:0]           perData,
   input  wire logic                  cntWr,
   input  wire logic [15:0]           cntData,
   input  wire logic                  pitWr,
   input  wire lpc_pkg::lpc_pit_ctrl_t pitData,
   input  wire lpc_pkg::lpc_flags_t   intEn,
   input  wire logic                  evEnCmp,
   input  wire logic                  evEnOvf,
   input  wire logic                  flagClrWr,
   input  wire lpc_pkg::lpc_flags_t   flagClr,
   input  wire logic                  sleepIdle,
   input  wire logic                  sleepStandby,
   input  wire logic                  dbgHalt,
   input  wire logic                  debug_run_bit,
   output logic [15:0]                count,
   output lpc_pkg::lpc_flags_t        flags,
   output logic                       irqCounter,
   output logic                       irqPit,
   output logic                       evCmp,
   output logic                       evOvf,
   output logic [7:0]                 pitEvents,
   output logic                       wakeReq,
   output logic                       ctrlBusy,
   output logic                       compare_sync_busy,
   output logic                       period_sync_busy,
   output logic                       count_sync_busy,
   output logic                       pitBusy
);
   // Mask of the low n bits of a prescaler or timer count
   function automatic logic [14:0] lowMask(input logic [3:0] n);
      lowMask = 15'((32'h1 << n) - 32'h1);
   endfunction

   // Reference clock path state
   logic                   ulpPrev_q, ulpPrev_d;        // Last ULP level
   logic [4:0]             ulpDiv_q, ulpDiv_d;          // Divide-by-32 stage
   logic                   refPrev_q, refPrev_d;        // Last selected level
   logic                   refSel;                      // Selected reference
   logic                   refTick;                     // One mclk per slow edge

   // Clock select and rising-edge tick
   always_comb begin
      ulpPrev_d = refUlp;
      ulpDiv_d  = ulpDiv_q + 5'((refUlp && !ulpPrev_q) ? 1 : 0);
      case (clkSel)
         lpc_pkg::SRC_XTAL: refSel = refXtal;
         lpc_pkg::SRC_EXT:  refSel = refExt;
         lpc_pkg::SRC_ULP:  refSel = refUlp;
         default:           refSel = ulpDiv_q[lpc_pkg::ULP_DIV_W-1];
      endcase
      refPrev_d = refSel;
      refTick   = refSel && !refPrev_q;                // Each level must span an mclk
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ulpPrev_q <= 1'b0;
         ulpDiv_q  <= 5'h0;
         refPrev_q <= 1'b0;
      end else begin
         ulpPrev_q <= ulpPrev_d;
         ulpDiv_q  <= ulpDiv_d;
         refPrev_q <= refPrev_d;
      end
   end

   // Slow-domain registers and their pending shadows
   lpc_pkg::lpc_ctrl_t     ctrl_q, ctrl_d, ctrlSh_q, ctrlSh_d;
   lpc_pkg::lpc_pit_ctrl_t pit_q, pit_d, pitSh_q, pitSh_d;
   logic [15:0]            cmp_q, cmp_d, cmpSh_q, cmpSh_d;
   logic [15:0]            per_q, per_d, perSh_q, perSh_d;
   logic [15:0]            cnt_q, cnt_d, cntSh_q, cntSh_d;
   logic [4:0]             pend_q, pend_d;              // ctrl,cmp,per,cnt,pit
   logic [14:0]            presc_q, presc_d;            // Prescaler count
   logic [14:0]            pitCnt_q, pitCnt_d;          // Interval timer count
   logic                   halted;                      // Debug halt in force
   logic                   rtcRun;                      // Counter may advance
   logic                   prescTick;                   // Counter tick
   logic                   pitTick;                     // Timer tick
   logic                   cmpHit, ovfHit;              // Events of this tick
   logic                   pitHit;                      // Timer interrupt event
   logic [7:0]             pitEvHit;                    // Timer event lines

   // Counter, prescaler, timer and write crossing
   always_comb begin
      halted    = dbgHalt && !debug_run_bit;
      // Standby stops counting unless asked; idle keeps it going
      rtcRun    = ctrl_q.enable && !halted && !(sleepStandby && !ctrl_q.runStdby);
      prescTick = refTick && rtcRun &&
                  ((presc_q & lowMask(ctrl_q.presc)) == lowMask(ctrl_q.presc));
      pitTick   = refTick && pit_q.enable && !halted;
      cmpHit    = prescTick && (cnt_q == cmp_q);
      ovfHit    = prescTick && (cnt_q == per_q);
      pitHit    = pitTick && (pit_q.period != 4'h0) && (pit_q.period <= lpc_pkg::PIT_PER_MAX)
                  && ((pitCnt_q & lowMask(pit_q.period + 4'h1)) ==
                      lowMask(pit_q.period + 4'h1));
      for (int k = 0; k < lpc_pkg::PIT_EV_N; k++) begin
         pitEvHit[k] = pitTick && ((pitCnt_q & lowMask(4'(lpc_pkg::PIT_EV_TOP - k))) ==
                                   lowMask(4'(lpc_pkg::PIT_EV_TOP - k)));
      end
      presc_d  = (refTick && rtcRun) ? presc_q + 15'h1 : presc_q;
      pitCnt_d = pitTick ? pitCnt_q + 15'h1 : (pit_q.enable ? pitCnt_q : 15'h0);
      cnt_d    = cnt_q;
      if (ovfHit) begin
         cnt_d = lpc_pkg::CNT_RST;
      end else if (prescTick) begin
         cnt_d = cnt_q + 16'h1;
      end
      ctrl_d = ctrl_q;
      cmp_d  = cmp_q;
      per_d  = per_q;
      pit_d  = pit_q;
      pend_d = pend_q;
      // Pending writes land on the next slow edge, then busy drops
      if (refTick) begin
         if (pend_q[4]) ctrl_d = ctrlSh_q;
         if (pend_q[3]) cmp_d  = cmpSh_q;
         if (pend_q[2]) per_d  = perSh_q;
         if (pend_q[1]) cnt_d  = cntSh_q;
         if (pend_q[0]) pit_d  = pitSh_q;
         pend_d = 5'h0;
      end
      // A new write is only taken while its register is idle
      ctrlSh_d = ctrlSh_q;
      cmpSh_d  = cmpSh_q;
      perSh_d  = perSh_q;
      cntSh_d  = cntSh_q;
      pitSh_d  = pitSh_q;
      if (ctrlWr && !pend_q[4]) begin ctrlSh_d = ctrlData; pend_d[4] = 1'b1; end
      if (cmpWr && !pend_q[3])  begin cmpSh_d = cmpData;   pend_d[3] = 1'b1; end
      if (perWr && !pend_q[2])  begin perSh_d = perData;   pend_d[2] = 1'b1; end
      if (cntWr && !pend_q[1])  begin cntSh_d = cntData;   pend_d[1] = 1'b1; end
      if (pitWr && !pend_q[0])  begin pitSh_d = pitData;   pend_d[0] = 1'b1; end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_q   <= '0;
         ctrlSh_q <= '0;
         pit_q    <= '0;
         pitSh_q  <= '0;
         cmp_q    <= lpc_pkg::CMP_RST;
         cmpSh_q  <= lpc_pkg::CMP_RST;
         per_q    <= lpc_pkg::PER_RST;
         perSh_q  <= lpc_pkg::PER_RST;
         cnt_q    <= lpc_pkg::CNT_RST;
         cntSh_q  <= lpc_pkg::CNT_RST;
         pend_q   <= 5'h0;
         presc_q  <= 15'h0;
         pitCnt_q <= 15'h0;
      end else begin
         ctrl_q   <= ctrl_d;
         ctrlSh_q <= ctrlSh_d;
         pit_q    <= pit_d;
         pitSh_q  <= pitSh_d;
         cmp_q    <= cmp_d;
         cmpSh_q  <= cmpSh_d;
         per_q    <= per_d;
         perSh_q  <= perSh_d;
         cnt_q    <= cnt_d;
         cntSh_q  <= cntSh_d;
         pend_q   <= pend_d;
         presc_q  <= presc_d;
         pitCnt_q <= pitCnt_d;
      end
   end

   // Flags, events and requests
   lpc_pkg::lpc_flags_t    flags_q, flags_d;            // Sticky flags
   lpc_pkg::lpc_flags_t    setV;                        // Set vector
   logic                   evCmp_q, evCmp_d;            // Compare event pulse
   logic                   evOvf_q, evOvf_d;            // Overflow event pulse
   logic [7:0]             pitEv_q, pitEv_d;            // Timer event pulses

   always_comb begin
      setV     = '{periodic_interval_timer: pitHit, cmp: cmpHit, ovf: ovfHit};
      // Set wins over a clear in the same cycle
      flags_d  = (flags_q & ~(flagClrWr ? flagClr : '0)) | setV;
      evCmp_d  = cmpHit && evEnCmp;
      evOvf_d  = ovfHit && evEnOvf;
      pitEv_d  = pitEvHit;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         flags_q <= '0;
         evCmp_q <= 1'b0;
         evOvf_q <= 1'b0;
         pitEv_q <= 8'h00;
      end else begin
         flags_q <= flags_d;
         evCmp_q <= evCmp_d;
         evOvf_q <= evOvf_d;
         pitEv_q <= pitEv_d;
      end
   end

   assign count      = cnt_q;
   assign flags      = flags_q;
   assign irqCounter = (flags_q.cmp && intEn.cmp) || (flags_q.ovf && intEn.ovf);
   assign irqPit     = flags_q.periodic_interval_timer && intEn.periodic_interval_timer;
   assign wakeReq    = (irqCounter || irqPit) && (sleepIdle || sleepStandby);
   assign evCmp      = evCmp_q;
   assign evOvf      = evOvf_q;
   assign pitEvents  = pitEv_q;
   assign ctrlBusy   = pend_q[4];
   assign compare_sync_busy    = pend_q[3];
   assign period_sync_busy    = pend_q[2];
   assign count_sync_busy    = pend_q[1];
   assign pitBusy    = pend_q[0];

   // Checks
   property p_wrap; @(posedge mclk) disable iff (rst)
      (prescTick && cnt_q == per_q && !pend_q[1]) |=> (cnt_q == 16'h0) && evOvf == $past(evEnOvf);
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap at period");
   property p_cmpFlag; @(posedge mclk) disable iff (rst)
      cmpHit |=> flags_q.cmp;
   endproperty
   a_cmpFlag: assert property (p_cmpFlag) else $error("compare flag missing");
   property p_irq; @(posedge mclk) disable iff (rst)
      ((flags_q.ovf && intEn.ovf) |-> irqCounter) and
      ((irqCounter && !flagClrWr) ##1 (intEn == $past(intEn)) |-> irqCounter);
   endproperty
   a_irq: assert property (p_irq) else $error("request not raised");
   property p_clear; @(posedge mclk) disable iff (rst)
      (flagClrWr && flagClr.periodic_interval_timer && !pitHit) |=> !flags_q.periodic_interval_timer;
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared");
   property p_count; @(posedge mclk) disable iff (rst)
      (prescTick && cnt_q != per_q && !(refTick && pend_q[1])) |=> cnt_q == $past(cnt_q) + 16'h1;
   endproperty
   a_count: assert property (p_count) else $error("count step wrong");
   property p_stop; @(posedge mclk) disable iff (rst)
      (!ctrl_q.enable && !pend_q[1]) |=> $stable(cnt_q);
   endproperty
   a_stop: assert property (p_stop) else $error("disabled counter moved");
   property p_busy; @(posedge mclk) disable iff (rst)
      (cmpWr && !compare_sync_busy) |=> compare_sync_busy;
   endproperty
   a_busy: assert property (p_busy) else $error("busy not shown");
   property p_dbg; @(posedge mclk) disable iff (rst)
      (dbgHalt && !debug_run_bit) |-> !prescTick && !pitTick;
   endproperty
   a_dbg: assert property (p_dbg) else $error("ran while halted");
   property p_wake; @(posedge mclk) disable iff (rst)
      (irqPit && sleepStandby) |-> wakeReq;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake request");
   c_ovf:  cover property (@(posedge mclk) disable iff (rst) evOvf);
   c_cmp:  cover property (@(posedge mclk) disable iff (rst) irqCounter && flags_q.cmp);
   c_pit:  cover property (@(posedge mclk) disable iff (rst) irqPit);
   c_busy: cover property (@(posedge mclk) disable iff (rst) count_sync_busy ##1 !count_sync_busy);
endmodule

// ==== sim/testbench.sv ====
/* Self-checking bench for lpc_counter: counting, sources, compare and wrap,
   flags, sleep and debug gating, interval timer. Assumes the design's own
   assertions run alongside and references toggle in step with mclk. */
`timescale 1ns/1ns
module testbench;
   logic                   mclk, rst, lvl;           // Clock, reset, reference level
   logic [2:0]             refMask;                  // Toggling refs {ulp,ext,xtal}
   logic [1:0]             clkSel;                   // Live source select
   logic                   ctrlWr, cmpWr, perWr, cntWr, pitWr, flagClrWr;
   lpc_pkg::lpc_ctrl_t     ctrlData;                 // Counter control word
   lpc_pkg::lpc_pit_ctrl_t pitData;                  // Timer control word
   logic [15:0]            cmpData, perData, cntData;
   lpc_pkg::lpc_flags_t    intEn, flagClr, flags;
   logic                   evEnCmp, evEnOvf, sleepIdle, sleepStandby, dbgHalt, debug_run_bit;
   logic [15:0]            count, base;              // Counter and snapshot
   logic                   irqCounter, irqPit, evCmp, evOvf, wakeReq;
   logic [7:0]             pitEvents;
   logic                   ctrlBusy, compare_sync_busy, period_sync_busy, count_sync_busy, pitBusy;
   int                     n_errors, checked, nCmp, nOvf, nP7, nP6, c, p, k;
   logic [3:0]             mode [5] = '{4'h8, 4'h4, 4'h2, 4'h3, 4'h0}; // idle,stby,halt,halt+debug-run,run
   logic [15:0]            runs [5] = '{16'h3, 16'h0, 16'h0, 16'h3, 16'h3};

   lpc_counter u_lpc_counter (
      .mclk(mclk), .rst(rst), .refXtal(lvl & refMask[0]), .refExt(lvl & refMask[1]),
      .refUlp(lvl & refMask[2]), .clkSel(clkSel), .ctrlWr(ctrlWr), .ctrlData(ctrlData),
      .cmpWr(cmpWr), .cmpData(cmpData), .perWr(perWr), .perData(perData),
      .cntWr(cntWr), .cntData(cntData), .pitWr(pitWr), .pitData(pitData),
      .intEn(intEn), .evEnCmp(evEnCmp), .evEnOvf(evEnOvf), .flagClrWr(flagClrWr),
      .flagClr(flagClr), .sleepIdle(sleepIdle), .sleepStandby(sleepStandby),
      .dbgHalt(dbgHalt), .debug_run_bit(debug_run_bit), .count(count), .flags(flags),
      .irqCounter(irqCounter), .irqPit(irqPit), .evCmp(evCmp), .evOvf(evOvf),
      .pitEvents(pitEvents), .wakeReq(wakeReq), .ctrlBusy(ctrlBusy), .compare_sync_busy(compare_sync_busy),
      .period_sync_busy(period_sync_busy), .count_sync_busy(count_sync_busy), .pitBusy(pitBusy));

   // Free-running 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Event pulses tallied here, since they stand one cycle only
   always @(posedge mclk) begin
      nCmp += int'(evCmp === 1'b1);
      nOvf += int'(evOvf === 1'b1);
      nP7 += int'(pitEvents[7] === 1'b1);
      nP6 += int'(pitEvents[6] === 1'b1);
   end

   // Compare and report
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Wait n edges, then step off the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // Reference periods, each level held two mclk, twice the one-mclk minimum
   task automatic tick(input int n);
      repeat (n) begin
         lvl = 1'b1;
         cyc(2);
         lvl = 1'b0;
         cyc(2);
      end
   endtask

   // Counter after n prescaled ticks; wraps to zero on the tick after top
   function automatic logic [15:0] expCount(input logic [15:0] origin, input int n,
                                            input logic [15:0] top);
      expCount = origin;
      repeat (n) expCount = (expCount == top) ? 16'h0000 : expCount + 16'h0001;
   endfunction

   // Write one register (0 ctrl,1 cmp,2 per,3 cnt,4 pit), for 1..3 try a refused write, land it
   task automatic wr(input int sel, input logic [15:0] v);
      ctrlData = v[5:0];
      pitData = v[4:0];
      {cmpData, perData, cntData} = {3{v}};
      {ctrlWr, cmpWr, perWr, cntWr, pitWr} = 5'h10 >> sel;
      cyc(1);
      {ctrlWr, cmpWr, perWr, cntWr, pitWr} = '0;
      chk(16'({ctrlBusy, compare_sync_busy, period_sync_busy, count_sync_busy, pitBusy}), 16'h10 >> sel, "busy");
      // Second write while busy must be dropped
      if (sel inside {[1:3]}) begin
         {cmpData, perData, cntData} = {3{~v}};
         {cmpWr, perWr, cntWr} = 3'h4 >> (sel - 1);
         cyc(1);
         {cmpWr, perWr, cntWr} = '0;
      end
      tick(1);
      chk(16'({ctrlBusy, compare_sync_busy, period_sync_busy, count_sync_busy, pitBusy}), 16'h0, "busy stuck");
   endtask

   // Write-one-to-clear pulse
   task automatic clr(input logic [2:0] m);
      flagClr = m;
      flagClrWr = 1'b1;
      cyc(1);
      flagClrWr = 1'b0;
      cyc(1);
   endtask

   task automatic tally_and_finish();
      $display("Checks %0d, errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Watchdog, far beyond the few thousand cycles the run needs
   initial begin
      #400000;
      n_errors++;
      $display("Error at %0t: watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      {lvl, clkSel, ctrlWr, cmpWr, perWr, cntWr, pitWr, flagClrWr} = '0;
      {ctrlData, pitData, cmpData, perData, cntData, intEn, flagClr} = '0;
      {evEnCmp, evEnOvf, sleepIdle, sleepStandby, dbgHalt, debug_run_bit} = '0;
      {n_errors, checked, nCmp, nOvf, nP7, nP6} = '0;
      refMask = 3'h1;
      rst = 1'b1;
      k = int'($urandom(7368));
      cyc(2);
      rst = 1'b0;
      chk(16'({flags, irqCounter, irqPit, wakeReq, evCmp, evOvf, pitEvents}), 16'h0, "rst");
      chk(count, 16'h0, "reset count");
      // Plain counting, then prescaler divides by 2, 4 and 8
      wr(0, 16'h01);
      c = $urandom_range(20, 1);
      base = count;
      tick(c);
      chk(count, base + 16'(c), "count");
      for (k = 1; k < 4; k++) begin
         wr(0, 16'(k << 1) | 16'h1);
         base = count;
         tick(3 << k);
         chk(count, base + 16'h3, "prescaled count");
      end
      wr(0, 16'h00);
      base = count;
      tick(3);
      chk(count, base, "disabled count");
      wr(0, 16'h01);
      // Each source counts, one other source ignored; last one divides by 32
      for (int s = 0; s < 4; s++) begin
         clkSel = s[1:0];
         refMask = (s == 0) ? 3'h2 : 3'h1;
         base = count;
         tick(3);
         chk(count, base, "wrong source");
         refMask = (s == 3) ? 3'h4 : 3'h1 << s;
         base = count;
         tick((s == 3) ? 64 : 3);
         chk(count, base + ((s == 3) ? 16'h2 : 16'h3), "source");
      end
      clkSel = 2'h0;
      refMask = 3'h1;
      // Compare and wrap with four enable mixes, event and interrupt enables set alike
      c = $urandom_range(8, 3);
      p = c + $urandom_range(6, 2);
      wr(1, 16'(c));
      wr(2, 16'(p));
      for (k = 0; k < 4; k++) begin
         {evEnCmp, evEnOvf} = 2'(k);
         intEn = 3'(k);
         wr(3, 16'(k));
         chk(count, 16'(k), "count load");
         wr(3, 16'h0);
         clr(3'h7);
         {nCmp, nOvf} = '0;
         tick(c);
         chk(16'(flags), 16'h0, "early compare");
         tick(1);
         chk(16'(flags), 16'h2, "compare flag");
         chk(16'(nCmp), 16'(k[1]), "compare event");
         chk(16'(irqCounter), 16'(k[1]), "compare irq");
         tick(p - c - 1);
         chk(count, 16'(p), "at period");
         tick(1);
         chk(count, 16'h0, "wrap");
         chk(16'(flags), 16'h3, "overflow flag");
         chk(16'(nOvf), 16'(k[0]), "overflow event");
         chk(16'(irqCounter), 16'(k != 0), "irq");
      end
      clr(3'h0);
      chk(16'(flags), 16'h3, "zero clear");
      clr(3'h1);
      chk(16'(flags), 16'h2, "one clear");
      sleepIdle = 1'b1;
      cyc(1);
      chk(16'(wakeReq), 16'h1, "wake");
      clr(3'h7);
      chk(16'({irqCounter, wakeReq}), 16'h0, "no wake");
      // Sleep and debug gating, standby without keep-running
      for (k = 0; k < 5; k++) begin
         {sleepIdle, sleepStandby, dbgHalt, debug_run_bit} = mode[k];
         base = count;
         tick(3);
         chk(count, expCount(base, int'(runs[k]), 16'(p)), "gating");
      end
      wr(0, 16'h21);
      sleepStandby = 1'b1;
      base = count;
      tick(3);
      chk(count, expCount(base, 3, 16'(p)), "standby run");
      sleepStandby = 1'b0;
      // Interval timer with the counter stopped
      wr(0, 16'h00);
      intEn = 3'h4;
      base = count;
      for (p = 1; p < 4; p++) begin
         wr(4, 16'(p << 1) | 16'h1);
         // Stale flag from the last period would skip the alignment wait
         clr(3'h4);
         repeat (40) if (flags.periodic_interval_timer !== 1'b1) tick(1);
         clr(3'h4);
         tick((2 << p) - 1);
         chk(16'({flags.periodic_interval_timer, irqPit}), 16'h0, "early interval");
         tick(1);
         chk(16'({flags.periodic_interval_timer, irqPit}), 16'h3, "interval");
      end
      chk(count, base, "counter idle");
      {nP7, nP6} = '0;
      tick(128);
      chk(16'(nP7), 16'h2, "event 64");
      chk(16'(nP6), 16'h1, "event 128");
      wr(4, 16'h01);
      clr(3'h4);
      tick(16);
      chk(16'(flags.periodic_interval_timer), 16'h0, "period off");
      wr(4, 16'h00);
      nP7 = 0;
      tick(64);
      chk(16'(nP7), 16'h0, "timer off");
      tally_and_finish();
   end
endmodule
